//--- include/dewg_pkg.sv
package dewg_pkg;
	// Clock and timing
	localparam int DEWG_CLK_MHZ = 200;
	localparam int DEWG_PWRT_MS = 72;
	localparam int DEWG_PWRT_CYCLES = DEWG_PWRT_MS * 1000 * DEWG_CLK_MHZ;
	localparam int DEWG_ERASE_US = 2;
	localparam int DEWG_ERASE_CYCLES = DEWG_ERASE_US * DEWG_CLK_MHZ;
	localparam int DEWG_PROG_US = 2;
	localparam int DEWG_PROG_CYCLES = DEWG_PROG_US * DEWG_CLK_MHZ;
	localparam int DEWG_TMR_W = 16;

	// Array shape
	localparam int DEWG_ADDR_W = 8;
	localparam int DEWG_DEPTH = 256;

	// Register offsets
	localparam logic [11:0] DEWG_ADR_IE2 = 12'hfa0;
	localparam logic [11:0] DEWG_ADR_IF2 = 12'hfa1;
	localparam logic [11:0] DEWG_ADR_IP2 = 12'hfa2;
	localparam logic [11:0] DEWG_ADR_CTL = 12'hfa6;
	localparam logic [11:0] DEWG_ADR_UNLOCK = 12'hfa7;
	localparam logic [11:0] DEWG_ADR_DATA = 12'hfa8;
	localparam logic [11:0] DEWG_ADR_ADDR = 12'hfa9;
	localparam logic [11:0] DEWG_ADR_GIC = 12'hff2;

	// Control register bit positions and the done flag bit
	localparam int DEWG_B_MEMSEL = 7;
	localparam int DEWG_B_CFGSEL = 6;
	localparam int DEWG_B_FREE = 4;
	localparam int DEWG_B_ABORT = 3;
	localparam int DEWG_B_PERMIT = 2;
	localparam int DEWG_B_WR = 1;
	localparam int DEWG_B_RD = 0;
	localparam int DEWG_B_DONE = 4;

	// Reset values and codes
	localparam logic [7:0] DEWG_RST_IP2 = 8'h1f;
	localparam logic [7:0] DEWG_RST_IF2 = 8'h00;
	localparam logic [7:0] DEWG_RST_IE2 = 8'h00;
	localparam logic [7:0] DEWG_RST_GIC = 8'h00;
	localparam logic [7:0] DEWG_RST_BYTE = 8'h00;
	localparam logic [7:0] DEWG_MASK_IF2 = 8'h1e;
	localparam logic [7:0] DEWG_MASK_GIC0 = 8'h01;
	localparam logic [7:0] DEWG_UNLOCK_1 = 8'h55;
	localparam logic [7:0] DEWG_UNLOCK_2 = 8'haa;
	localparam logic [7:0] DEWG_ERASED = 8'hff;

	typedef enum logic [1:0] {DEWG_LOCKED, DEWG_GOT_FIRST, DEWG_ARMED} dewg_unlock_e;
	typedef enum logic [1:0] {DEWG_W_IDLE, DEWG_W_ERASE, DEWG_W_PROG} dewg_wphase_e;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} dewg_sfr_req_s;

	typedef struct packed {
		logic                   wr;
		logic [DEWG_ADDR_W-1:0] addr;
		logic [7:0]             wdata;
	} dewg_ext_req_s;
endpackage

//--- design/dewg_cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dewg_cycle_timer #(
	parameter int W = 16
) (
	input  wire logic         clk_sys_in,
	input  wire logic         sys_rst_in,
	input  wire logic         start_in,
	input  wire logic         abort_in,
	input  wire logic [W-1:0] length_in,
	output logic              busy_out,
	output logic              done_out
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         busy;
	} dewg_tmr_s;

	dewg_tmr_s st_reg;
	dewg_tmr_s st_next;

	always_comb begin
		st_next = st_reg;
		if (abort_in) begin
			st_next.busy = 1'b0;
		end else if (start_in) begin
			// Length of zero is treated as one cycle
			st_next.busy = 1'b1;
			st_next.cnt = (length_in == '0) ? '0 : length_in - W'(1);
		end else if (st_reg.busy) begin
			if (st_reg.cnt == '0) begin
				st_next.busy = 1'b0;
			end else begin
				st_next.cnt = st_reg.cnt - W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign busy_out = st_reg.busy;
	assign done_out = st_reg.busy && (st_reg.cnt == '0) && !abort_in;
endmodule // dewg_cycle_timer
`default_nettype wire

//--- design/dewg_top.sv
// What this block does
// - Write permit cleared at power-up
// - No write during 72 ms power-up timer
// - Write needs permit, 55h, AAh, start
// - Code protect blocks external array access
// - Processor access ignores code protect
// - Start bit held until write ends
// - Unlock port stores nothing, reads zero
// - Byte array through address, data registers
// - Start bits software-set only, hardware-cleared
// - Reset during write sets abort flag
// - Write end clears start, sets done flag
// - Control, address and data registers frozen while write runs
`timescale 1ns/1ps
`default_nettype none
module dewg_top
	import dewg_pkg::*;
#(
	parameter int PWRT_CYCLES  = DEWG_PWRT_CYCLES,
	parameter int ERASE_CYCLES = DEWG_ERASE_CYCLES,
	parameter int PROG_CYCLES  = DEWG_PROG_CYCLES
) (
	input  wire logic          clk_sys_in,
	input  wire logic          sys_rst_in,
	input  wire dewg_sfr_req_s sfr_req_in,
	output logic [7:0]         sfr_rdata_out,
	input  wire logic          ext_reset_in,
	input  wire logic          watchdog_reset_in,
	input  wire logic          code_protect_in,
	input  wire logic          ext_req_in,
	input  wire dewg_ext_req_s ext_cmd_in,
	output logic [7:0]         ext_rdata_out,
	output logic               ext_ack_out,
	output logic               ext_refused_out,
	output logic               write_busy_out,
	output logic               done_irq_out
);
	localparam int PW = $clog2(PWRT_CYCLES + 1);
	typedef struct packed {
		logic [DEWG_DEPTH-1:0][7:0] mem;
		logic                       mem_sel;
		logic                       cfg_sel;
		logic                       free;
		logic                       abort;
		logic                       permit;
		logic                       wr;
		logic                       rd;
		logic [DEWG_ADDR_W-1:0]     addr;
		logic [7:0]                 data;
		logic [7:0]                 ie2;
		logic [7:0]                 if2;
		logic [7:0]                 ip2;
		logic [7:0]                 gic;
		dewg_unlock_e               unlock;
		dewg_wphase_e               wph;
		logic                       pwrt_started;
		logic                       pwrt_done;
		logic [7:0]                 rdata;
		logic [7:0]                 ext_rdata;
		logic                       ext_ack;
		logic                       ext_refused;
	} dewg_state_s;
	dewg_state_s st_reg;
	dewg_state_s st_next;
	logic                  any_rst;
	logic                  ctl_wr;
	logic                  wr_go;
	logic                  tmr_start;
	logic                  tmr_done;
	logic                  pwrt_end;
	logic [DEWG_TMR_W-1:0] tmr_len;

	////////////////////////////////////////////////////////////////////////////////
	// Timers
	assign any_rst = ext_reset_in || watchdog_reset_in;
	assign ctl_wr = sfr_req_in.wr && (sfr_req_in.addr == DEWG_ADR_CTL);
	// Permit must already be set from an earlier write, never in the same one
	assign wr_go = ctl_wr && sfr_req_in.wdata[DEWG_B_WR] && !st_reg.wr && st_reg.permit
		&& (st_reg.unlock == DEWG_ARMED) && st_reg.pwrt_done
		&& !st_reg.mem_sel && !st_reg.cfg_sel && !any_rst;
	assign tmr_start = wr_go || (st_reg.wph == DEWG_W_ERASE && tmr_done);
	assign tmr_len = wr_go ? DEWG_TMR_W'(ERASE_CYCLES) : DEWG_TMR_W'(PROG_CYCLES);
	dewg_cycle_timer #(.W(DEWG_TMR_W)) u_write_timer (
		.clk_sys_in (clk_sys_in),
		.sys_rst_in (sys_rst_in),
		.start_in   (tmr_start),
		.abort_in   (any_rst),
		.length_in  (tmr_len),
		.busy_out   (),
		.done_out   (tmr_done)
	);
	dewg_cycle_timer #(.W(PW)) u_pwrt_timer (
		.clk_sys_in (clk_sys_in),
		.sys_rst_in (sys_rst_in),
		.start_in   (!st_reg.pwrt_started),
		.abort_in   (1'b0),
		.length_in  (PW'(PWRT_CYCLES)),
		.busy_out   (),
		.done_out   (pwrt_end)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.pwrt_started = 1'b1;
		st_next.ext_ack = 1'b0;
		st_next.ext_refused = 1'b0;
		if (pwrt_end) begin
			st_next.pwrt_done = 1'b1;
		end
		// Read strobe lasts exactly one cycle
		if (st_reg.rd) begin
			st_next.data = st_reg.mem[st_reg.addr];
			st_next.rd = 1'b0;
		end
		if (sfr_req_in.wr) begin
			unique case (sfr_req_in.addr)
				DEWG_ADR_UNLOCK: begin
					// Pattern detector only, nothing stored
					if (sfr_req_in.wdata == DEWG_UNLOCK_1) begin
						st_next.unlock = DEWG_GOT_FIRST;
					end else if (sfr_req_in.wdata == DEWG_UNLOCK_2
						&& st_reg.unlock == DEWG_GOT_FIRST) begin
						st_next.unlock = DEWG_ARMED;
					end else begin
						st_next.unlock = DEWG_LOCKED;
					end
				end
				default: begin
					st_next.unlock = DEWG_LOCKED;
				end
			endcase
			if (st_reg.wph == DEWG_W_IDLE) begin
				unique case (sfr_req_in.addr)
					DEWG_ADR_CTL: begin
						st_next.mem_sel = sfr_req_in.wdata[DEWG_B_MEMSEL];
						st_next.cfg_sel = sfr_req_in.wdata[DEWG_B_CFGSEL];
						st_next.free = sfr_req_in.wdata[DEWG_B_FREE];
						st_next.abort = sfr_req_in.wdata[DEWG_B_ABORT];
						st_next.permit = sfr_req_in.wdata[DEWG_B_PERMIT];
						// Zeros written to the start bits are ignored
						if (sfr_req_in.wdata[DEWG_B_RD] && !st_reg.mem_sel && !wr_go) begin
							st_next.rd = 1'b1;
						end
						if (wr_go) begin
							st_next.wr = 1'b1;
							st_next.wph = DEWG_W_ERASE;
						end
					end
					DEWG_ADR_DATA: st_next.data = sfr_req_in.wdata;
					DEWG_ADR_ADDR: st_next.addr = sfr_req_in.wdata;
					DEWG_ADR_IE2: st_next.ie2 = sfr_req_in.wdata;
					DEWG_ADR_IF2: st_next.if2 = sfr_req_in.wdata & DEWG_MASK_IF2;
					DEWG_ADR_IP2: st_next.ip2 = sfr_req_in.wdata;
					DEWG_ADR_GIC: st_next.gic = sfr_req_in.wdata;
					default: ;
				endcase
			end else begin
				// Only interrupt enable, flag, priority and GIC registers stay writable mid-cycle
				unique case (sfr_req_in.addr)
					DEWG_ADR_IE2: st_next.ie2 = sfr_req_in.wdata;
					DEWG_ADR_IF2: st_next.if2 = sfr_req_in.wdata & DEWG_MASK_IF2;
					DEWG_ADR_IP2: st_next.ip2 = sfr_req_in.wdata;
					DEWG_ADR_GIC: st_next.gic = sfr_req_in.wdata;
					default: ;
				endcase
			end
		end
		// Self-timed erase then program
		if (tmr_done) begin
			unique case (st_reg.wph)
				DEWG_W_ERASE: begin
					st_next.mem[st_reg.addr] = DEWG_ERASED;
					st_next.wph = DEWG_W_PROG;
				end
				DEWG_W_PROG: begin
					st_next.mem[st_reg.addr] = st_reg.data;
					st_next.wph = DEWG_W_IDLE;
					st_next.wr = 1'b0;
					st_next.if2[DEWG_B_DONE] = 1'b1;
				end
				default: ;
			endcase
		end
		// Processor register reads, one cycle latency
		unique case (sfr_req_in.addr)
			DEWG_ADR_CTL: st_next.rdata = {st_reg.mem_sel, st_reg.cfg_sel, 1'b0, st_reg.free,
				st_reg.abort, st_reg.permit, st_reg.wr, st_reg.rd};
			DEWG_ADR_DATA: st_next.rdata = st_reg.data;
			DEWG_ADR_ADDR: st_next.rdata = st_reg.addr;
			DEWG_ADR_IE2: st_next.rdata = st_reg.ie2 & DEWG_MASK_IF2;
			DEWG_ADR_IF2: st_next.rdata = st_reg.if2;
			DEWG_ADR_IP2: st_next.rdata = st_reg.ip2 & DEWG_MASK_IF2;
			DEWG_ADR_GIC: st_next.rdata = st_reg.gic;
			default: st_next.rdata = DEWG_RST_BYTE;
		endcase
		if (!sfr_req_in.rd) begin
			st_next.rdata = st_reg.rdata;
		end
		// External programming path; it must not disturb a running write
		if (ext_req_in) begin
			if (code_protect_in || st_reg.wph != DEWG_W_IDLE) begin
				st_next.ext_refused = 1'b1;
			end else begin
				st_next.ext_ack = 1'b1;
				if (ext_cmd_in.wr) begin
					st_next.mem[ext_cmd_in.addr] = ext_cmd_in.wdata;
				end else begin
					st_next.ext_rdata = st_reg.mem[ext_cmd_in.addr];
				end
			end
		end
		// Warm resets keep the array and select bits for tracing
		if (any_rst) begin
			if (st_reg.wph != DEWG_W_IDLE) begin
				st_next.abort = 1'b1;
			end
			st_next.wph = DEWG_W_IDLE;
			st_next.wr = 1'b0;
			st_next.rd = 1'b0;
			st_next.free = 1'b0;
			st_next.permit = 1'b0;
			st_next.unlock = DEWG_LOCKED;
			st_next.addr = DEWG_RST_BYTE;
			st_next.data = DEWG_RST_BYTE;
			st_next.ie2 = DEWG_RST_IE2;
			st_next.if2 = DEWG_RST_IF2;
			st_next.ip2 = DEWG_RST_IP2;
			st_next.gic = st_reg.gic & DEWG_MASK_GIC0;
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			// Array content after power-up is left as erased
			st_reg <= '0;
			st_reg.mem <= '1;
			st_reg.permit <= 1'b0;
			st_reg.ip2 <= DEWG_RST_IP2;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sfr_rdata_out = st_reg.rdata;
	assign ext_rdata_out = st_reg.ext_rdata;
	assign ext_ack_out = st_reg.ext_ack;
	assign ext_refused_out = st_reg.ext_refused;
	assign write_busy_out = st_reg.wr;
	assign done_irq_out = st_reg.if2[DEWG_B_DONE] && st_reg.ie2[DEWG_B_DONE];

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);

	chk_permit_cleared: assert property (any_rst |=> !st_reg.permit)
		else $error("permit survived reset");
	chk_pwrt_block: assert property (!st_reg.pwrt_done |-> st_reg.wph == DEWG_W_IDLE)
		else $error("write during power-up timer");
	chk_unlock_order: assert property ($rose(st_reg.wr) |->
		$past(st_reg.unlock) == DEWG_ARMED && $past(st_reg.permit))
		else $error("write started without unlock");
	chk_protect_ext: assert property (ext_req_in && code_protect_in |=>
		ext_refused_out && !ext_ack_out)
		else $error("external access not refused");
	chk_wr_held: assert property (st_reg.wph != DEWG_W_IDLE |-> st_reg.wr)
		else $error("start bit dropped mid write");
	chk_unlock_reads_zero: assert property (sfr_req_in.rd
		&& sfr_req_in.addr == DEWG_ADR_UNLOCK |=> sfr_rdata_out == DEWG_RST_BYTE)
		else $error("unlock port read nonzero");
	chk_read_one_cycle: assert property (st_reg.rd && !any_rst |=>
		!st_reg.rd && st_reg.data == $past(st_reg.mem[st_reg.addr]))
		else $error("read strobe wrong");
	chk_abort_flag: assert property (st_reg.wph != DEWG_W_IDLE && any_rst |=>
		st_reg.abort && !st_reg.wr)
		else $error("abort flag not set");
	chk_write_end: assert property (st_reg.wph == DEWG_W_PROG && tmr_done && !any_rst |=>
		!st_reg.wr && st_reg.if2[DEWG_B_DONE])
		else $error("write end not signalled");
	chk_addr_frozen: assert property (st_reg.wph != DEWG_W_IDLE && !any_rst |=>
		$stable(st_reg.addr) && $stable(st_reg.data))
		else $error("registers changed mid write");
	chk_erase_first: assert property (st_reg.wph == DEWG_W_ERASE && tmr_done && !any_rst |=>
		st_reg.wph == DEWG_W_PROG && st_reg.mem[st_reg.addr] == DEWG_ERASED)
		else $error("erase phase wrong");

	cov_write_done: cover property (st_reg.wph == DEWG_W_PROG ##1 st_reg.wph == DEWG_W_IDLE);
	cov_ext_refused: cover property (ext_refused_out);
	cov_write_aborted: cover property (st_reg.wr && any_rst);
endmodule // dewg_top
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dewg_pkg::*;

	localparam int PW = 20;
	localparam int ER = 8;
	localparam int PR = 8;

	logic          clk_sys_in      = 1'b0;
	logic          sys_rst_in      = 1'b1;
	logic          ext_reset_in    = 1'b0;
	logic          watchdog_reset_in = 1'b0;
	logic          code_protect_in = 1'b0;
	logic          ext_req_in      = 1'b0;
	dewg_sfr_req_s sfr_req_in      = '0;
	dewg_ext_req_s ext_cmd_in      = '0;
	logic [7:0]    sfr_rdata_out;
	logic [7:0]    ext_rdata_out;
	logic          ext_ack_out;
	logic          ext_refused_out;
	logic          write_busy_out;
	logic          done_irq_out;
	int            failures        = 0;
	int            tests_run       = 0;
	int            cycles          = 0;

	dewg_top #(.PWRT_CYCLES(PW), .ERASE_CYCLES(ER), .PROG_CYCLES(PR)) dut (
		.clk_sys_in      (clk_sys_in),
		.sys_rst_in      (sys_rst_in),
		.sfr_req_in      (sfr_req_in),
		.sfr_rdata_out   (sfr_rdata_out),
		.ext_reset_in    (ext_reset_in),
		.watchdog_reset_in (watchdog_reset_in),
		.code_protect_in (code_protect_in),
		.ext_req_in      (ext_req_in),
		.ext_cmd_in      (ext_cmd_in),
		.ext_rdata_out   (ext_rdata_out),
		.ext_ack_out     (ext_ack_out),
		.ext_refused_out (ext_refused_out),
		.write_busy_out  (write_busy_out),
		.done_irq_out    (done_irq_out)
	);

	initial begin
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("compares %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Refresh walk dominates, about 6700 cycles; ceiling leaves margin
	always @(posedge clk_sys_in) begin
		cycles <= cycles + 1;
		if (cycles == 12000) begin
			failures++;
			end_sim();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One idle cycle after every request keeps each strobe a clean pulse
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		sfr_req_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys_in);
		sfr_req_in <= '0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
		@(posedge clk_sys_in);
		sfr_req_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys_in);
		sfr_req_in <= '0;
		#1;
		chk(sfr_rdata_out, exp);
	endtask

	task automatic unlock_go();
		wr(DEWG_ADR_UNLOCK, DEWG_UNLOCK_1);
		wr(DEWG_ADR_UNLOCK, DEWG_UNLOCK_2);
		wr(DEWG_ADR_CTL, 8'h06);
	endtask

	task automatic busy_is(input logic exp);
		@(posedge clk_sys_in);
		#1;
		chk({7'h00, write_busy_out}, {7'h00, exp});
	endtask

	// Answer is a one-cycle pulse right after the take edge
	task automatic ext(input logic w, input logic [7:0] a, input logic [7:0] d,
			input logic exp_ack, input logic [7:0] exp_data);
		@(posedge clk_sys_in);
		ext_req_in <= 1'b1;
		ext_cmd_in <= '{wr: w, addr: a, wdata: d};
		@(posedge clk_sys_in);
		ext_req_in <= 1'b0;
		#1;
		chk({6'h00, ext_ack_out, ext_refused_out}, {6'h00, exp_ack, ~exp_ack});
		if (exp_ack && !w) begin
			chk(ext_rdata_out, exp_data);
		end
		@(posedge clk_sys_in);
		#1;
		chk({6'h00, ext_ack_out, ext_refused_out}, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_pwrt();
		rdchk(DEWG_ADR_CTL, 8'h00);
		wr(DEWG_ADR_CTL, 8'h04);
		unlock_go();
		busy_is(1'b0);
		$display("test pwrt done");
	endtask

	task automatic t_regs();
		rdchk(DEWG_ADR_UNLOCK, 8'h00);
		rdchk(DEWG_ADR_DATA, 8'h00);
		rdchk(DEWG_ADR_ADDR, 8'h00);
		rdchk(DEWG_ADR_IP2, 8'h1e);
		rdchk(DEWG_ADR_IF2, 8'h00);
		rdchk(12'h123, 8'h00);
		$display("test regs done");
	endtask

	task automatic t_sequence();
		wr(DEWG_ADR_CTL, 8'h00);
		unlock_go();
		busy_is(1'b0);
		wr(DEWG_ADR_CTL, 8'h04);
		wr(DEWG_ADR_UNLOCK, DEWG_UNLOCK_2);
		wr(DEWG_ADR_UNLOCK, DEWG_UNLOCK_1);
		wr(DEWG_ADR_CTL, 8'h06);
		busy_is(1'b0);
		wr(DEWG_ADR_UNLOCK, DEWG_UNLOCK_1);
		wr(DEWG_ADR_DATA, 8'h00);
		wr(DEWG_ADR_UNLOCK, DEWG_UNLOCK_2);
		wr(DEWG_ADR_CTL, 8'h06);
		busy_is(1'b0);
		wr(DEWG_ADR_DATA, 8'h3c);
		wr(DEWG_ADR_CTL, 8'h84);
		wr(DEWG_ADR_CTL, 8'h85);
		rdchk(DEWG_ADR_DATA, 8'h3c);
		wr(DEWG_ADR_UNLOCK, DEWG_UNLOCK_1);
		wr(DEWG_ADR_UNLOCK, DEWG_UNLOCK_2);
		wr(DEWG_ADR_CTL, 8'h86);
		busy_is(1'b0);
		$display("test sequence done");
	endtask

	task automatic t_write();
		int n;
		wr(DEWG_ADR_IE2, 8'h10);
		wr(DEWG_ADR_ADDR, 8'h10);
		wr(DEWG_ADR_DATA, 8'h5a);
		wr(DEWG_ADR_CTL, 8'h04);
		unlock_go();
		busy_is(1'b1);
		wr(DEWG_ADR_ADDR, 8'h33);
		wr(DEWG_ADR_CTL, 8'h00);
		ext(1'b0, 8'h10, 8'h00, 1'b0, 8'h00);
		busy_is(1'b1);
		n = 0;
		while (write_busy_out !== 1'b0 && n < 60) begin
			@(posedge clk_sys_in);
			#1;
			n++;
		end
		#1;
		chk({7'h00, write_busy_out}, 8'h00);
		rdchk(DEWG_ADR_IF2, 8'h10);
		chk({7'h00, done_irq_out}, 8'h01);
		rdchk(DEWG_ADR_ADDR, 8'h10);
		wr(DEWG_ADR_CTL, 8'h01);
		rdchk(DEWG_ADR_DATA, 8'h5a);
		rdchk(DEWG_ADR_CTL, 8'h00);
		wr(DEWG_ADR_IF2, 8'h00);
		busy_is(1'b0);
		chk({7'h00, done_irq_out}, 8'h00);
		$display("test write done");
	endtask

	task automatic t_external();
		ext(1'b0, 8'h10, 8'h00, 1'b1, 8'h5a);
		ext(1'b1, 8'h20, 8'h77, 1'b1, 8'h00);
		@(posedge clk_sys_in);
		code_protect_in <= 1'b1;
		ext(1'b0, 8'h10, 8'h00, 1'b0, 8'h00);
		ext(1'b1, 8'h20, 8'h00, 1'b0, 8'h00);
		wr(DEWG_ADR_ADDR, 8'h20);
		wr(DEWG_ADR_CTL, 8'h01);
		rdchk(DEWG_ADR_DATA, 8'h77);
		@(posedge clk_sys_in);
		code_protect_in <= 1'b0;
		$display("test external done");
	endtask

	// Both reset sources must leave the same trace behind
	task automatic t_abort();
		for (int k = 0; k < 2; k++) begin
			wr(DEWG_ADR_ADDR, 8'h40);
			wr(DEWG_ADR_DATA, 8'h11);
			wr(DEWG_ADR_CTL, 8'h04);
			unlock_go();
			busy_is(1'b1);
			@(posedge clk_sys_in);
			if (k == 0) begin
				ext_reset_in <= 1'b1;
			end else begin
				watchdog_reset_in <= 1'b1;
			end
			@(posedge clk_sys_in);
			ext_reset_in <= 1'b0;
			watchdog_reset_in <= 1'b0;
			#1;
			chk({7'h00, write_busy_out}, 8'h00);
			rdchk(DEWG_ADR_CTL, 8'h08);
			rdchk(DEWG_ADR_ADDR, 8'h00);
			wr(DEWG_ADR_CTL, 8'h00);
		end
		$display("test abort done");
	endtask

	// Refresh walk: read, unlock, rewrite, poll, step until the address wraps
	task automatic t_refresh();
		int n;
		logic [7:0] a;
		a = 8'h00;
		wr(DEWG_ADR_ADDR, a);
		do begin
			wr(DEWG_ADR_CTL, 8'h05);
			wr(DEWG_ADR_UNLOCK, DEWG_UNLOCK_1);
			wr(DEWG_ADR_UNLOCK, DEWG_UNLOCK_2);
			wr(DEWG_ADR_CTL, 8'h06);
			n = 0;
			do begin
				@(posedge clk_sys_in);
				#1;
				n++;
			end while (write_busy_out !== 1'b0 && n < 60);
			chk(8'(n), 8'(ER + PR));
			a++;
			wr(DEWG_ADR_ADDR, a);
		end while (a != 8'h00);
		wr(DEWG_ADR_CTL, 8'h00);
		rdchk(DEWG_ADR_ADDR, 8'h00);
		rdchk(DEWG_ADR_IF2, 8'h10);
		wr(DEWG_ADR_ADDR, 8'h10);
		wr(DEWG_ADR_CTL, 8'h01);
		rdchk(DEWG_ADR_DATA, 8'h5a);
		wr(DEWG_ADR_ADDR, 8'h20);
		wr(DEWG_ADR_CTL, 8'h01);
		rdchk(DEWG_ADR_DATA, 8'h77);
		$display("test refresh done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		t_pwrt();
		t_regs();
		repeat (PW) @(posedge clk_sys_in);
		t_sequence();
		t_write();
		t_external();
		t_abort();
		t_refresh();
		end_sim();
	end
endmodule // tb
`default_nettype wire
